// ===== src/serial_port_device.sv
// Functional notes
// - Four lines: clock, data in, data out, select.
// - Falling select starts a new register access.
// - Sample on rising clock, shift out on falling.
// - Host raises select; rising select ends any sequence.
// - Bytes of eight bits, most significant first.
// - Select strap sampled during hardware clear picks port.
// - Interrupt low active by default, high selectable.
// - First byte is header choosing sequence type.
// - Header bit 2 selects upper address half.
// - Header 40/44: address then one data byte.
// - Non-interleaved mode drives output only in read slots.
// - Header 48/4C: read data overlaps next address.
// - Interleaved modes need separate data lines.
// - Header 43/47: one address, many data bytes.
// - Header 41/45: non-interleaved reads, then write run.
// - Header 49/4D: interleaved reads, then write run.
// - FIFO window addresses in header 43 use an auto-advancing pointer; header 47 reaches only 80-FF, outside the window.
// - Write address ends read phase; data runs on.
module serial_port_device (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rstn,
    // Serial link toward the host.
    serial_port_if.device link,
    // Hardware clear pin and the strap it captures.
    input wire logic i_hw_clear_n,
    output logic o_serial_sel,
    // Register space access.
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_fifo,
    output logic [7:0] o_fifo_index,
    // Interrupt request pin.
    input wire logic i_irq_request,
    input wire logic i_irq_high,
    output logic o_irq,
    output logic o_irq_oe
);

    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] sdi_sync;
        logic [1:0] clr_sync;
        logic sclk_prev;
        serial_port_pkg::phase_type phase;
        serial_port_pkg::mode_type mode;
        logic half;
        logic [7:0] rx;
        logic [2:0] cnt;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic rd_wait;
        logic [7:0] pend;
        logic pend_v;
        logic [7:0] tx;
        logic sdo;
        logic drive;
        logic fifo;
        logic [7:0] fifo_idx;
        logic serial_sel;
        logic irq;
        logic irq_oe;
    } state_type;

    localparam state_type STATE_RESET = '{
        cs_sync: 2'h3,
        sclk_sync: 2'h0,
        sdi_sync: 2'h0,
        clr_sync: 2'h3,
        sclk_prev: 1'b0,
        phase: serial_port_pkg::PH_HDR,
        mode: serial_port_pkg::MD_NONE,
        half: 1'b0,
        rx: 8'h00,
        cnt: 3'h0,
        addr: 8'h00,
        wdata: 8'h00,
        wr: 1'b0,
        rd: 1'b0,
        rd_wait: 1'b0,
        pend: 8'h00,
        pend_v: 1'b0,
        tx: 8'h00,
        sdo: 1'b1,
        drive: 1'b0,
        fifo: 1'b0,
        fifo_idx: 8'h00,
        serial_sel: serial_port_pkg::STRAP_RESET,
        irq: 1'b1,
        irq_oe: 1'b0
    };

    state_type state_reg;
    state_type state_next;
    logic active;
    logic rise;
    logic fall;
    logic [7:0] byte_in;

    // Maps a header byte to its sequence type; anything else is refused.
    function automatic serial_port_pkg::mode_type decode_header(input logic [7:0] hdr);
        logic [7:0] base;
        base = hdr & ~serial_port_pkg::HDR_HALF_MASK;
        case (base)
            serial_port_pkg::HDR_ALT_NI: decode_header = serial_port_pkg::MD_ALT_NI;
            serial_port_pkg::HDR_ALT_IL: decode_header = serial_port_pkg::MD_ALT_IL;
            serial_port_pkg::HDR_CONST: decode_header = serial_port_pkg::MD_CONST;
            serial_port_pkg::HDR_RW_NI: decode_header = serial_port_pkg::MD_RW_NI;
            serial_port_pkg::HDR_RW_IL: decode_header = serial_port_pkg::MD_RW_IL;
            default: decode_header = serial_port_pkg::MD_NONE;
        endcase
    endfunction : decode_header

    // True for addresses that reach the FIFO entry rather than a register.
    function automatic logic in_fifo_window(input logic [7:0] adr);
        in_fifo_window = (adr <= serial_port_pkg::FIFO_WIN_LAST) || (adr == serial_port_pkg::FIFO_ALIAS_A)
            || (adr == serial_port_pkg::FIFO_ALIAS_B);
    endfunction : in_fifo_window

    // Link inputs are only read after their second synchroniser stage.
    assign active = ~state_reg.cs_sync[1] & state_reg.serial_sel & state_reg.clr_sync[1];
    assign rise = state_reg.sclk_sync[1] & ~state_reg.sclk_prev;
    assign fall = ~state_reg.sclk_sync[1] & state_reg.sclk_prev;
    assign byte_in = {state_reg.rx[6:0], state_reg.sdi_sync[1]};

    // Next-state logic for the whole port.
    always_comb begin
        state_next = state_reg;
        state_next.cs_sync = {state_reg.cs_sync[0], link.cs_n};
        state_next.sclk_sync = {state_reg.sclk_sync[0], link.sclk};
        state_next.sdi_sync = {state_reg.sdi_sync[0], link.sdi};
        state_next.clr_sync = {state_reg.clr_sync[0], i_hw_clear_n};
        state_next.sclk_prev = state_reg.sclk_sync[1];
        state_next.wr = 1'b0;
        state_next.rd = 1'b0;
        state_next.rd_wait = state_reg.rd;

        // Read data is taken the cycle after the read strobe, well before the next falling edge.
        if (state_reg.rd_wait) begin
            state_next.pend = i_reg_rdata;
            state_next.pend_v = 1'b1;
        end

        // The FIFO pointer moves on after every data access it served.
        if ((state_reg.wr | state_reg.rd) & state_reg.fifo) begin
            state_next.fifo_idx = state_reg.fifo_idx + 8'h01;
        end

        // The strap follows chip select for as long as the hardware clear is held.
        if (!state_reg.clr_sync[1]) begin
            state_next.serial_sel = state_reg.cs_sync[1];
        end

        // A high-active request is push-pull; a low-active one only pulls down.
        state_next.irq = i_irq_high ? i_irq_request : ~i_irq_request;
        state_next.irq_oe = i_irq_high | i_irq_request;

        if (!active) begin
            // Select high ends the access and drops any partial byte.
            state_next.phase = serial_port_pkg::PH_HDR;
            state_next.cnt = 3'h0;
            state_next.drive = 1'b0;
            state_next.sdo = 1'b1;
            state_next.pend_v = 1'b0;
            state_next.fifo = 1'b0;
        end else begin
            // Output changes only on falling edges; a slot starts when the bit count is zero.
            if (fall) begin
                if (state_reg.cnt == 3'h0) begin
                    if (state_reg.pend_v) begin
                        state_next.sdo = state_reg.pend[7];
                        state_next.tx = {state_reg.pend[6:0], 1'b0};
                        state_next.drive = 1'b1;
                        state_next.pend_v = 1'b0;
                    end else begin
                        state_next.sdo = 1'b1;
                        state_next.drive = 1'b0;
                    end
                end else if (state_reg.drive) begin
                    state_next.sdo = state_reg.tx[7];
                    state_next.tx = {state_reg.tx[6:0], 1'b0};
                end
            end

            // Input bits are shifted in on rising edges, eight to a byte.
            if (rise) begin
                state_next.rx = byte_in;
                state_next.cnt = state_reg.cnt + 3'h1;
                if (state_reg.cnt == serial_port_pkg::LAST_BIT) begin
                    case (state_reg.phase)
                        serial_port_pkg::PH_HDR: begin
                            state_next.mode = decode_header(byte_in);
                            state_next.half = byte_in[serial_port_pkg::HDR_HALF_BIT];
                            if (decode_header(byte_in) == serial_port_pkg::MD_NONE) begin
                                state_next.phase = serial_port_pkg::PH_IGNORE;
                            end else begin
                                state_next.phase = serial_port_pkg::PH_ADDR;
                            end
                        end
                        serial_port_pkg::PH_ADDR: begin
                            state_next.addr = {state_reg.half, byte_in[6:0]};
                            state_next.fifo = (state_reg.mode == serial_port_pkg::MD_CONST)
                                & in_fifo_window({state_reg.half, byte_in[6:0]});
                            state_next.fifo_idx = 8'h00;
                            if (byte_in[serial_port_pkg::ADDR_READ_BIT]) begin
                                state_next.rd = 1'b1;
                                case (state_reg.mode)
                                    serial_port_pkg::MD_CONST: state_next.phase = serial_port_pkg::PH_RRUN;
                                    serial_port_pkg::MD_ALT_IL,
                                    serial_port_pkg::MD_RW_IL: state_next.phase = serial_port_pkg::PH_ADDR;
                                    default: state_next.phase = serial_port_pkg::PH_RSLOT;
                                endcase
                            end else begin
                                case (state_reg.mode)
                                    serial_port_pkg::MD_CONST,
                                    serial_port_pkg::MD_RW_NI,
                                    serial_port_pkg::MD_RW_IL: state_next.phase = serial_port_pkg::PH_WRUN;
                                    default: state_next.phase = serial_port_pkg::PH_WDATA;
                                endcase
                            end
                        end
                        serial_port_pkg::PH_WDATA: begin
                            state_next.wr = 1'b1;
                            state_next.wdata = byte_in;
                            state_next.phase = serial_port_pkg::PH_ADDR;
                        end
                        serial_port_pkg::PH_RSLOT: begin
                            // Whatever the host shifted in during a read slot is dropped.
                            state_next.phase = serial_port_pkg::PH_ADDR;
                        end
                        serial_port_pkg::PH_WRUN: begin
                            state_next.wr = 1'b1;
                            state_next.wdata = byte_in;
                        end
                        serial_port_pkg::PH_RRUN: begin
                            state_next.rd = 1'b1;
                        end
                        serial_port_pkg::PH_IGNORE: begin
                            state_next.phase = serial_port_pkg::PH_IGNORE;
                        end
                        default: begin
                            state_next.phase = serial_port_pkg::PH_IGNORE;
                        end
                    endcase
                end
            end
        end
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Every output comes straight from the state register.
    assign link.sdo = state_reg.sdo;
    assign link.sdo_oe = state_reg.drive;
    assign o_serial_sel = state_reg.serial_sel;
    assign o_reg_wr = state_reg.wr;
    assign o_reg_rd = state_reg.rd;
    assign o_reg_addr = state_reg.addr;
    assign o_reg_wdata = state_reg.wdata;
    assign o_reg_fifo = state_reg.fifo;
    assign o_fifo_index = state_reg.fifo_idx;
    assign o_irq = state_reg.irq;
    assign o_irq_oe = state_reg.irq_oe;

endmodule : serial_port_device

// ===== src/serial_port_host.sv
module serial_port_host #(
    parameter int HALF_CYCLES = serial_port_pkg::LINK_HALF_CYCLES
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rstn,
    // Serial link toward the device.
    serial_port_if.host link,
    // Bytes to send; the first byte of an access is its header.
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    output logic o_tx_ready,
    input wire logic i_stop,
    // Bytes received, one per slot.
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_busy
);

    // The device needs several clocks per half period to see both edges through its synchronisers.
    if (HALF_CYCLES < serial_port_pkg::MIN_HALF_CYCLES || HALF_CYCLES > 255) begin : g_check
        $error("HALF_CYCLES out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    typedef struct packed {
        serial_port_pkg::host_state_type st;
        logic [7:0] cnt;
        logic [2:0] bit_idx;
        logic [7:0] tx;
        logic [7:0] rx;
        logic rx_valid;
        logic [1:0] sdo_sync;
        logic sclk;
        logic cs_n;
        logic sdi;
    } state_type;

    localparam state_type STATE_RESET = '{
        st: serial_port_pkg::HS_IDLE,
        cnt: 8'h00,
        bit_idx: 3'h0,
        tx: 8'h00,
        rx: 8'h00,
        rx_valid: 1'b0,
        sdo_sync: 2'h3,
        sclk: 1'b0,
        cs_n: 1'b1,
        sdi: 1'b0
    };

    state_type state_reg;
    state_type state_next;
    logic take;

    // A new byte is taken only between bytes, with the clock resting low.
    assign o_tx_ready = (state_reg.st == serial_port_pkg::HS_IDLE) || (state_reg.st == serial_port_pkg::HS_HOLD);
    assign take = o_tx_ready & i_tx_valid;

    // Next-state logic; the clock idles low and data changes while it is low.
    always_comb begin
        state_next = state_reg;
        state_next.sdo_sync = {state_reg.sdo_sync[0], link.sdo_line};
        state_next.rx_valid = 1'b0;
        case (state_reg.st)
            serial_port_pkg::HS_IDLE,
            serial_port_pkg::HS_HOLD: begin
                if (take) begin
                    state_next.cs_n = 1'b0;
                    state_next.sdi = i_tx_byte[7];
                    state_next.tx = {i_tx_byte[6:0], 1'b0};
                    state_next.bit_idx = 3'h0;
                    state_next.cnt = 8'h00;
                    state_next.st = serial_port_pkg::HS_LOW;
                end else if (i_stop && state_reg.st == serial_port_pkg::HS_HOLD) begin
                    state_next.cs_n = 1'b1;
                    state_next.cnt = 8'h00;
                    state_next.st = serial_port_pkg::HS_CLOSE;
                end
            end
            serial_port_pkg::HS_LOW: begin
                state_next.cnt = state_reg.cnt + 8'h01;
                if (state_reg.cnt == HALF_LAST) begin
                    state_next.sclk = 1'b1;
                    state_next.cnt = 8'h00;
                    state_next.st = serial_port_pkg::HS_HIGH;
                end
            end
            serial_port_pkg::HS_HIGH: begin
                state_next.cnt = state_reg.cnt + 8'h01;
                if (state_reg.cnt == HALF_LAST) begin
                    // Sampling late in the high phase leaves the device's falling-edge output time to settle.
                    state_next.rx = {state_reg.rx[6:0], state_reg.sdo_sync[1]};
                    state_next.sclk = 1'b0;
                    state_next.cnt = 8'h00;
                    if (state_reg.bit_idx == serial_port_pkg::LAST_BIT) begin
                        state_next.rx_valid = 1'b1;
                        state_next.st = serial_port_pkg::HS_HOLD;
                    end else begin
                        state_next.bit_idx = state_reg.bit_idx + 3'h1;
                        state_next.sdi = state_reg.tx[7];
                        state_next.tx = {state_reg.tx[6:0], 1'b0};
                        state_next.st = serial_port_pkg::HS_LOW;
                    end
                end
            end
            serial_port_pkg::HS_CLOSE: begin
                // Select stays high at least one half period before the next access.
                state_next.cnt = state_reg.cnt + 8'h01;
                if (state_reg.cnt == HALF_LAST) begin
                    state_next.st = serial_port_pkg::HS_IDLE;
                end
            end
            default: begin
                state_next = STATE_RESET;
            end
        endcase
    end

    // State register.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Link and user outputs from the state register.
    assign link.sclk = state_reg.sclk;
    assign link.cs_n = state_reg.cs_n;
    assign link.sdi = state_reg.sdi;
    assign o_rx_valid = state_reg.rx_valid;
    assign o_rx_byte = state_reg.rx;
    assign o_busy = ~state_reg.cs_n;

endmodule : serial_port_host

// ===== src/serial_port_if.sv
interface serial_port_if;

    // Serial clock, chip select and host-to-device data, driven by the host.
    logic sclk;
    logic cs_n;
    logic sdi;
    // Device-to-host data with its output enable.
    logic sdo;
    logic sdo_oe;
    // Level seen on the return line; a pull-up holds it high when undriven.
    logic sdo_line;

    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport device (
        input sclk,
        input cs_n,
        input sdi,
        output sdo,
        output sdo_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output sdi,
        input sdo_line
    );

endinterface : serial_port_if

// ===== src/serial_port_pkg.sv
package serial_port_pkg;

    // Header codes with the address-half bit cleared; bit 2 picks the upper half.
    localparam logic [7:0] HDR_ALT_NI = 8'h40;
    localparam logic [7:0] HDR_ALT_IL = 8'h48;
    localparam logic [7:0] HDR_CONST = 8'h43;
    localparam logic [7:0] HDR_RW_NI = 8'h41;
    localparam logic [7:0] HDR_RW_IL = 8'h49;
    localparam int HDR_HALF_BIT = 2;
    localparam logic [7:0] HDR_HALF_MASK = 8'h04;

    // Address byte layout: top bit marks a read, the low seven bits the address.
    localparam int ADDR_READ_BIT = 7;

    // Addresses that reach the current FIFO entry in constant-address mode.
    localparam logic [7:0] FIFO_WIN_LAST = 8'h1F;
    localparam logic [7:0] FIFO_ALIAS_A = 8'h6A;
    localparam logic [7:0] FIFO_ALIAS_B = 8'h7A;

    // Bits in one byte slot on either data line.
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Timing of the serial clock made by the host end.
    localparam int CLOCK_PERIOD_NS = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int MIN_HALF_CYCLES = 4;

    // Strap value assumed until the hardware clear samples chip select.
    localparam logic STRAP_RESET = 1'b1;

    // Sequence phases of the device end.
    typedef enum logic [6:0] {
        PH_HDR = 7'h01,
        PH_ADDR = 7'h02,
        PH_WDATA = 7'h04,
        PH_RSLOT = 7'h08,
        PH_WRUN = 7'h10,
        PH_RRUN = 7'h20,
        PH_IGNORE = 7'h40
    } phase_type;

    // Sequence types selected by the header byte.
    typedef enum logic [5:0] {
        MD_NONE = 6'h01,
        MD_ALT_NI = 6'h02,
        MD_ALT_IL = 6'h04,
        MD_CONST = 6'h08,
        MD_RW_NI = 6'h10,
        MD_RW_IL = 6'h20
    } mode_type;

    // States of the host end.
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_LOW = 5'h02,
        HS_HIGH = 5'h04,
        HS_HOLD = 5'h08,
        HS_CLOSE = 5'h10
    } host_state_type;

endpackage : serial_port_pkg

// ===== verif/serial_host_register_port_bench.sv
module serial_host_register_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic hw_clear_n = 1'b1;
    logic tx_valid = 1'b0;
    logic stop = 1'b0;
    logic irq_request = 1'b0;
    logic irq_high = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rdata = 8'h00;
    logic tx_ready, rx_valid, busy, serial_sel, reg_wr, reg_rd, reg_fifo, irq, irq_oe;
    logic [7:0] rx_byte, reg_addr, reg_wdata, fifo_index;
    logic [7:0] last_index = 8'h00;
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] exp_mem [256] = '{default: 8'h00};
    logic [7:0] hdrs [10] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h43, 8'h47, 8'h41, 8'h45, 8'h49, 8'h4D};
    logic [7:0] rx_q [$];
    logic [31:0] seed = 32'hC1775EC7;
    int bad_count = 0;
    int n_compared = 0;

    serial_port_if link ();
    serial_port_host #(.HALF_CYCLES(8)) u_serial_port_host (.i_clock(i_clock), .i_rstn(i_rstn), .link(link.host),
        .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_tx_ready(tx_ready), .i_stop(stop), .o_rx_valid(rx_valid),
        .o_rx_byte(rx_byte), .o_busy(busy));
    serial_port_device u_serial_port_device (.i_clock(i_clock), .i_rstn(i_rstn), .link(link.device),
        .i_hw_clear_n(hw_clear_n), .o_serial_sel(serial_sel), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata), .o_reg_fifo(reg_fifo),
        .o_fifo_index(fifo_index), .i_irq_request(irq_request), .i_irq_high(irq_high), .o_irq(irq), .o_irq_oe(irq_oe));
    serial_port_props #(.HALF_CYCLES(8)) u_serial_port_props (.i_clock(i_clock), .i_rstn(i_rstn), .sclk(link.sclk),
        .cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 i_clock = ~i_clock;

    // Register space behind the device; read data is ready one cycle after the strobe.
    always @(posedge i_clock) begin
        if (reg_wr) mem[reg_addr] <= reg_wdata;
        if (reg_rd) rdata <= mem[reg_addr];
        if (reg_wr && reg_fifo) last_index <= fifo_index;
    end

    // A hang ends the run as a failure instead of stalling forever.
    initial begin
        repeat (90000) @(posedge i_clock);
        bad_count++;
        tally_and_finish();
    end

    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : next_rand

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expected);
        n_compared++;
        if (seen !== expected) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, expected, seen);
        end
    endtask : check

    task automatic check_mem();
        foreach (mem[i]) check("register", mem[i], exp_mem[i]);
    endtask : check_mem

    // One byte slot: offer the byte, hold it until taken, then keep what came back.
    task automatic xfer(input logic [7:0] b);
        tx_valid <= 1'b1;
        tx_byte <= b;
        do @(negedge i_clock); while (!tx_ready);
        @(posedge i_clock);
        tx_valid <= 1'b0;
        do @(negedge i_clock); while (!rx_valid);
        rx_q.push_back(rx_byte);
        @(posedge i_clock);
    endtask : xfer

    // A whole access; the gap after it keeps select high long enough for the device to see it.
    task automatic run(input logic [7:0] h, input logic [7:0] q[$]);
        rx_q = {};
        xfer(h);
        foreach (q[i]) xfer(q[i]);
        stop <= 1'b1;
        do @(negedge i_clock); while (!tx_ready);
        @(posedge i_clock);
        stop <= 1'b0;
        do @(negedge i_clock); while (busy);
        repeat (12) @(posedge i_clock);
    endtask : run

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Random addresses stay in 40-5F so that constant-address runs reach the FIFO window only in the fifo step run.
    initial begin
        logic [31:0] r;
        logic [7:0] h, a, d, w, e;
        repeat (2) @(posedge i_clock);
        i_rstn <= 1'b1;
        hw_clear_n <= 1'b0;
        repeat (6) @(posedge i_clock);
        hw_clear_n <= 1'b1;
        repeat (6) @(posedge i_clock);
        check("strap", {7'h00, serial_sel}, 8'h01);
        repeat (3) begin
            foreach (hdrs[k]) begin
                r = next_rand();
                h = hdrs[k];
                a = {3'h2, r[4:0]};
                w = {3'h2, r[12:8]};
                d = r[23:16];
                e = exp_mem[{h[2], a[6:0]}];
                case (h & 8'hFB)
                    8'h40: begin
                        run(h, {a, d, a | 8'h80, 8'h00});
                        check("write slot", rx_q[2], 8'hFF);
                        check("read", rx_q[4], d);
                    end
                    8'h48: begin
                        run(h, {a, d, a | 8'h80, a | 8'h80, 8'h00});
                        check("read", rx_q[4], d);
                        check("read", rx_q[5], d);
                    end
                    8'h43: begin
                        run(h, {a, r[31:24], d});
                        run(h, {a | 8'h80, 8'h00, 8'h00});
                        check("const read", rx_q[3], d);
                    end
                    8'h41: begin
                        run(h, {a | 8'h80, 8'h00, w, r[31:24], d});
                        check("read", rx_q[2], e);
                    end
                    default: begin
                        run(h, {a | 8'h80, w, r[31:24], d});
                        check("read", rx_q[2], e);
                    end
                endcase
                exp_mem[{h[2], (h[1:0] == 2'b01) ? w[6:0] : a[6:0]}] = d;
                check_mem();
            end
        end
        run(8'h42, {8'h20, 8'h5A, 8'hA0, 8'h00});
        check("ignored", rx_q[4], 8'hFF);
        check_mem();
        run(8'h43, {8'h10, d, d, d});
        check("fifo step", last_index, 8'h02);
        for (int m = 0; m < 4; m++) begin
            irq_request <= m[0];
            irq_high <= m[1];
            repeat (3) @(negedge i_clock);
            check("irq", {6'h00, irq, irq_oe}, {6'h00, m[1] ? m[0] : !m[0], m[1] | m[0]});
            @(posedge i_clock);
        end
        tally_and_finish();
    end
endmodule : serial_host_register_port_bench

// ===== verif/serial_port_props.sv
module serial_port_props #(
    parameter int HALF_CYCLES = serial_port_pkg::LINK_HALF_CYCLES
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rstn,
    // Link lines between the two ends.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking main_cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic [2:0] rise_count_reg;
    logic [7:0] high_count_reg;

    // Clock rises per frame modulo a byte, and the length of each high phase.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rise_count_reg <= 3'h0;
            high_count_reg <= 8'h00;
        end else begin
            rise_count_reg <= cs_n ? 3'h0 : rise_count_reg + {2'h0, $rose(sclk)};
            high_count_reg <= sclk ? high_count_reg + 8'h01 : 8'h00;
        end
    end

    property p_sclk_idle;
        cs_n && $past(cs_n) |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("clock moved while idle");
    property p_high_phase;
        $fell(sclk) |-> high_count_reg == 8'(HALF_CYCLES);
    endproperty
    a_high_phase: assert property (p_high_phase) else $error("clock high phase length wrong");
    property p_select_fall;
        $fell(cs_n) |-> !sclk;
    endproperty
    a_select_fall: assert property (p_select_fall) else $error("select fell with clock high");
    property p_sdi_launch;
        $changed(sdi) |-> !sclk;
    endproperty
    a_sdi_launch: assert property (p_sdi_launch) else $error("host data moved while clock high");
    property p_sdo_launch;
        sdo_oe && $changed(sdo) |-> !sclk;
    endproperty
    a_sdo_launch: assert property (p_sdo_launch) else $error("device data moved while clock high");
    property p_byte_frame;
        $rose(cs_n) |-> rise_count_reg == 3'h0;
    endproperty
    a_byte_frame: assert property (p_byte_frame) else $error("frame ended inside a byte");
    property p_oe_release;
        cs_n [*6] |-> !sdo_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("device drives after deselect");
    property p_oe_rise;
        $rose(sdo_oe) |-> !sclk && !$past(cs_n, 3); // The device sees select only after its two sync stages.
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("device drive began off a slot start");

    // Main traffic shapes that should each be seen at least once.
    c_read_slot: cover property ($rose(sdo_oe));
    c_zero_back: cover property (sdo_oe && !sdo_line);
    c_frame_end: cover property ($rose(cs_n));
endmodule : serial_port_props
